//--- supervisor_defines.svh
`ifndef SUPERVISOR_DEFINES_SVH
`define SUPERVISOR_DEFINES_SVH

// Register map of the plain register port
`define ADDR_CONTROL         4'h0
`define ADDR_STATUS          4'h1
`define ADDR_WIDTH           4

// Control register field positions
`define CTRL_RESET_HOLD_HI   7
`define CTRL_WD_SEL_HI       6
`define CTRL_WD_SEL_LO       5
`define CTRL_RESET_HOLD_LO   0
`define CTRL_RESET_VALUE     8'h00

// Status register field positions
`define STAT_RESET_ACTIVE    0
`define STAT_WD_EXPIRED      1
`define STAT_MAIN_FAIL       2
`define STAT_SECOND_FAIL     3
`define STAT_BATTERY         4
`define STAT_WRITE_PROTECT   5

// Internal time base: 50 MHz clock divided to a 10 us tick
`define CLK_PERIOD_NS        20
`define TICK_NS              10000
`define TICK_CYCLES          (`TICK_NS / `CLK_PERIOD_NS)

// Reset hold times in ms, watchdog periods in ms
`define HOLD0_MS             50
`define HOLD1_MS             200
`define HOLD2_MS             400
`define HOLD3_MS             800
`define WD0_MS               25
`define WD1_MS               200
`define WD2_MS               1400
`define TICKS_PER_MS         (1000000 / `TICK_NS)

// Manual reset debounce, in ticks
`define DEBOUNCE_TICKS       16'h03e8

`endif

//--- supervisor_pkg.sv
`include "supervisor_defines.svh"
package supervisor_pkg;

  typedef enum logic [1:0] {
    HOLD_50MS  = 2'h0,
    HOLD_200MS = 2'h1,
    HOLD_400MS = 2'h2,
    HOLD_800MS = 2'h3
  } hold_sel_type;

  typedef enum logic [1:0] {
    WD_SHORT = 2'h0,
    WD_MID   = 2'h1,
    WD_LONG  = 2'h2,
    WD_OFF   = 2'h3
  } wd_sel_type;

  typedef struct packed {
    logic main_above_trip;
    logic main_above_backup_hi;
    logic main_below_backup_lo;
    logic second_above_trip;
    logic backup_present;
  } sense_type;

  typedef struct packed {
    logic [`ADDR_WIDTH-1:0] addr;
    logic [7:0]             wdata;
    logic                   wr;
    logic                   rd;
  } reg_req_type;

endpackage

//--- sync_stage.sv
`timescale 1ns/1ps
module sync_stage #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic [WIDTH-1:0] async_in,
  input  wire logic [WIDTH-1:0] init_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // Reset value held in a parameter-free input: sync reset, so no async capture
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta_q   <= init_in;
      sync_out <= init_in;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

//--- bus_activity_detect.sv
`timescale 1ns/1ps
module bus_activity_detect (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic scl_in,
  input  wire logic sda_in,
  input  wire logic enable_in,
  output logic      restart_out
);

  logic scl_q;
  logic sda_q;
  logic started_q;
  logic clocked_q;
  logic start_cond;
  logic stop_cond;

  // Inputs already synchronised by the caller
  assign start_cond = scl_q && scl_in && sda_q && !sda_in;
  assign stop_cond  = scl_q && scl_in && !sda_q && sda_in;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  // Start, then a falling clock, then stop: the minimum restart sequence
  always_ff @(posedge clk_in) begin
    if (rst_in || !enable_in) begin
      started_q   <= 1'b0;
      clocked_q   <= 1'b0;
      restart_out <= 1'b0;
    end else begin
      restart_out <= 1'b0;
      if (start_cond) begin
        started_q <= 1'b1;
        clocked_q <= 1'b0;
      end else if (started_q && scl_q && !scl_in) begin
        clocked_q <= 1'b1;
      end else if (stop_cond) begin
        restart_out <= started_q && clocked_q; // R1 R14
        started_q   <= 1'b0;
        clocked_q   <= 1'b0;
      end
    end
  end

endmodule

//--- supervisor_reset_watchdog.sv
`timescale 1ns/1ps
`include "supervisor_defines.svh"
// Notes on behaviour
// (R1) Start, clock fall, stop restarts watchdog
// (R2) No restart within period: watchdog output active
// (R3) Write protect high blocks all writes; a byte taken before it rose still commits at the stop
// (R4) Battery flag follows switched supply source
// (R5) Main above trip, else hysteretic main/backup choice
// (R6) No bus activity while on backup
// (R7) Reset active from power application
// (R8) Release only after main held good
// (R9) Manual reset holds reset plus hold time
// (R10) Reset when main below trip
// (R11) Main fail stays until hold time passes
// (R12) Second fail follows second comparator directly
// (R13) Second monitor stops without any supply
// (R14) Any complete bus sequence restarts watchdog
// (R15) Host minimum: start, low, high, stop
// (R16) Two stored bits select watchdog period
// (R17) Watchdog output low when timed out
// (R18) Reset polarity variant chosen by parameter
// (R19) Stop after data byte stores selection bits
// (R20) Periods counted on internal oscillator ticks
// (R21) Comparators and manual reset synchronised
module supervisor_reset_watchdog #(
  parameter bit          RESET_ACTIVE_HIGH = 1'b0,
  parameter int unsigned TICK_CYCLES       = `TICK_CYCLES,
  parameter int unsigned TICKS_PER_MS      = `TICKS_PER_MS,
  parameter logic [7:0]  CONTROL_INIT      = `CTRL_RESET_VALUE
) (
  input  wire logic                   clk_in,
  input  wire logic                   rst_in,
  input  wire supervisor_pkg::sense_type sense_in,
  input  wire logic                   manual_reset_in_n,
  input  wire logic                   write_protect_in,
  input  wire logic                   scl_in,
  input  wire logic                   sda_in,
  input  wire logic [`ADDR_WIDTH-1:0] reg_addr_in,
  input  wire logic [7:0]             reg_wdata_in,
  input  wire logic                   reg_wr_in,
  input  wire logic                   reg_rd_in,
  input  wire logic                   store_stop_in,
  output logic [7:0]                  reg_rdata_out,
  output logic                        reset_out,
  output logic                        main_supply_fail_out,
  output logic                        early_low_supply_n_out,
  output logic                        second_supply_fail_n_out,
  output logic                        battery_active_out,
  output logic                        watchdog_out_n,
  output logic                        watchdog_oe_out,
  output logic                        bus_enable_out
);

  localparam int unsigned DIV_W = $clog2(TICK_CYCLES + 1);
  localparam int unsigned CNT_W = 20;

  function automatic logic [CNT_W-1:0] ms_ticks(input int unsigned ms);
    ms_ticks = CNT_W'(ms * TICKS_PER_MS);
  endfunction

  // Synchronised inputs
  supervisor_pkg::sense_type sense_s;
  logic                      mr_n_s;
  logic                      scl_s;
  logic                      sda_s;
  logic                      wp_s;

  sync_stage #(
    .WIDTH ($bits(supervisor_pkg::sense_type) + 4)
  ) u_sync (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .async_in ({sense_in, manual_reset_in_n, scl_in, sda_in, write_protect_in}),
    .init_in  ({$bits(supervisor_pkg::sense_type)'(0), 4'he}),
    .sync_out ({sense_s, mr_n_s, scl_s, sda_s, wp_s})
  ); // R21

  // Tick divider: the internal oscillator time base
  logic [DIV_W-1:0] div_q;
  logic             tick_q;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else if (div_q == DIV_W'(TICK_CYCLES - 1)) begin
      div_q  <= '0;
      tick_q <= 1'b1; // R20
    end else begin
      div_q  <= div_q + DIV_W'(1);
      tick_q <= 1'b0;
    end
  end

  // Control register (non-volatile selection bits)
  logic [7:0] control_q;
  logic [7:0] pending_q;
  logic       pending_valid_q;
  logic       on_backup_q;

  supervisor_pkg::hold_sel_type hold_sel;
  supervisor_pkg::wd_sel_type   wd_sel;

  assign hold_sel = supervisor_pkg::hold_sel_type'({control_q[`CTRL_RESET_HOLD_HI],
                                                    control_q[`CTRL_RESET_HOLD_LO]});
  assign wd_sel   = supervisor_pkg::wd_sel_type'({control_q[`CTRL_WD_SEL_HI],
                                                  control_q[`CTRL_WD_SEL_LO]});

  // Written byte waits for the stop before it is committed
  // On backup nothing is accepted and a half-done write is dropped
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      control_q       <= CONTROL_INIT;
      pending_q       <= '0;
      pending_valid_q <= 1'b0;
    end else if (on_backup_q) begin
      pending_valid_q <= 1'b0; // R6
    end else begin
      if (reg_wr_in && !wp_s && reg_addr_in == `ADDR_CONTROL) begin // R3
        pending_q       <= reg_wdata_in;
        pending_valid_q <= 1'b1;
      end else if (store_stop_in && pending_valid_q) begin
        control_q       <= {pending_q[7:5], 4'h0, pending_q[0]}; // R16 R19
        pending_valid_q <= 1'b0;
      end
    end
  end

  // Supply source selection with hysteresis
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      on_backup_q <= 1'b0;
    end else if (sense_s.main_above_trip) begin
      on_backup_q <= 1'b0; // R5
    end else if (sense_s.main_below_backup_lo) begin
      on_backup_q <= 1'b1; // R5
    end else if (sense_s.main_above_backup_hi) begin
      on_backup_q <= 1'b0; // R5
    end
  end

  // Manual reset debounce
  // Release is debounced too, which stretches a manual reset by one debounce time
  logic [15:0] mr_cnt_q;
  logic        mr_active_q;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mr_cnt_q    <= '0;
      mr_active_q <= 1'b0;
    end else if (mr_n_s == !mr_active_q) begin
      mr_cnt_q <= '0;
    end else if (tick_q) begin
      if (mr_cnt_q == `DEBOUNCE_TICKS) begin
        mr_active_q <= !mr_n_s;
        mr_cnt_q    <= '0;
      end else begin
        mr_cnt_q <= mr_cnt_q + 16'd1;
      end
    end
  end

  // Reset hold timer
  logic [CNT_W-1:0] hold_limit;
  logic [CNT_W-1:0] hold_cnt_q;
  logic             reset_cause;
  logic             reset_active_q;

  always_comb begin
    unique case (hold_sel)
      supervisor_pkg::HOLD_50MS:  hold_limit = ms_ticks(`HOLD0_MS);
      supervisor_pkg::HOLD_200MS: hold_limit = ms_ticks(`HOLD1_MS);
      supervisor_pkg::HOLD_400MS: hold_limit = ms_ticks(`HOLD2_MS);
      supervisor_pkg::HOLD_800MS: hold_limit = ms_ticks(`HOLD3_MS);
    endcase
  end

  assign reset_cause = !sense_s.main_above_trip || mr_active_q; // R9 R10

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      hold_cnt_q     <= '0;
      reset_active_q <= 1'b1; // R7
    end else if (reset_cause) begin
      hold_cnt_q     <= '0;
      reset_active_q <= 1'b1;
    end else if (reset_active_q && tick_q) begin
      if (hold_cnt_q >= hold_limit - CNT_W'(1)) begin
        reset_active_q <= 1'b0; // R8 R9
      end else begin
        hold_cnt_q <= hold_cnt_q + CNT_W'(1);
      end
    end
  end

  // Main fail: held until supply good for the hold time
  logic main_fail_q;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      main_fail_q <= 1'b1;
    end else if (!sense_s.main_above_trip) begin
      main_fail_q <= 1'b1;
    end else if (!reset_active_q && !mr_active_q) begin
      main_fail_q <= 1'b0; // R11
    end
  end

  // Watchdog
  logic             restart;
  logic [CNT_W-1:0] wd_limit;
  logic [CNT_W-1:0] wd_cnt_q;
  logic             wd_expired_q;

  bus_activity_detect u_bus (
    .clk_in      (clk_in),
    .rst_in      (rst_in),
    .scl_in      (scl_s),
    .sda_in      (sda_s),
    .enable_in   (!on_backup_q),
    .restart_out (restart)
  ); // R6

  always_comb begin
    unique case (wd_sel)
      supervisor_pkg::WD_SHORT: wd_limit = ms_ticks(`WD0_MS);
      supervisor_pkg::WD_MID:   wd_limit = ms_ticks(`WD1_MS);
      supervisor_pkg::WD_LONG:  wd_limit = ms_ticks(`WD2_MS);
      supervisor_pkg::WD_OFF:   wd_limit = '0;
    endcase
  end

  // Parked while reset is active, so each period starts at release
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wd_cnt_q     <= '0;
      wd_expired_q <= 1'b0;
    end else if (restart || wd_sel == supervisor_pkg::WD_OFF || reset_active_q) begin
      wd_cnt_q     <= '0; // R1 R14
      wd_expired_q <= 1'b0;
    end else if (tick_q) begin
      if (wd_cnt_q >= wd_limit - CNT_W'(1)) begin
        wd_expired_q <= 1'b1; // R2
      end else begin
        wd_cnt_q <= wd_cnt_q + CNT_W'(1);
      end
    end
  end

  // Second supply monitor: runs from the switched output, so it needs a supply
  logic second_fail_q;
  logic supply_present;

  assign supply_present = sense_s.main_above_trip || sense_s.main_above_backup_hi
                          || sense_s.backup_present; // R13

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      second_fail_q <= 1'b0;
    end else if (supply_present) begin
      second_fail_q <= !sense_s.second_above_trip; // R12
    end
    // No supply at all: last value held, monitor dead
  end

  // Reset pin: level set by the variant, conditions identical
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      reset_out <= RESET_ACTIVE_HIGH; // R7
    end else begin
      reset_out <= reset_active_q ? RESET_ACTIVE_HIGH : !RESET_ACTIVE_HIGH; // R18
    end
  end

  // Main supply flags
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      main_supply_fail_out   <= 1'b1;
      early_low_supply_n_out <= 1'b0;
    end else begin
      main_supply_fail_out   <= main_fail_q; // R11
      early_low_supply_n_out <= sense_s.main_above_trip; // R10
    end
  end

  // Second supply flag
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      second_supply_fail_n_out <= 1'b1;
    end else begin
      second_supply_fail_n_out <= !second_fail_q; // R12
    end
  end

  // Source flag and bus gate move together, so no frame is taken on backup
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      battery_active_out <= 1'b0;
      bus_enable_out     <= 1'b0;
    end else begin
      battery_active_out <= on_backup_q; // R4
      bus_enable_out     <= !on_backup_q; // R6
    end
  end

  // Open-drain watchdog pin: enable high while the pin is pulled low
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      watchdog_out_n  <= 1'b1;
      watchdog_oe_out <= 1'b0;
    end else begin
      watchdog_out_n  <= !wd_expired_q; // R17
      watchdog_oe_out <= wd_expired_q; // R17
    end
  end

  // Register read port
  logic [7:0] status;

  always_comb begin
    status                      = '0;
    status[`STAT_RESET_ACTIVE]  = reset_active_q;
    status[`STAT_WD_EXPIRED]    = wd_expired_q;
    status[`STAT_MAIN_FAIL]     = main_fail_q;
    status[`STAT_SECOND_FAIL]   = second_fail_q;
    status[`STAT_BATTERY]       = on_backup_q;
    status[`STAT_WRITE_PROTECT] = wp_s;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      reg_rdata_out <= '0;
    end else if (reg_rd_in && !on_backup_q) begin
      unique case (reg_addr_in)
        `ADDR_CONTROL: reg_rdata_out <= control_q;
        `ADDR_STATUS:  reg_rdata_out <= status;
        default:       reg_rdata_out <= '0;
      endcase
    end else begin
      reg_rdata_out <= '0;
    end
  end

endmodule

//--- supervisor_props.sv
`timescale 1ns/1ps
`include "supervisor_defines.svh"
module supervisor_props #(
  parameter bit          RESET_ACTIVE_HIGH = 1'b0,
  parameter int unsigned TICK_CYCLES       = `TICK_CYCLES,
  parameter int unsigned TICKS_PER_MS      = `TICKS_PER_MS
) (
  input wire logic                      clk_in,
  input wire logic                      rst_in,
  input wire supervisor_pkg::sense_type sense_in,
  input wire logic                      scl_in,
  input wire logic                      sda_in,
  input wire logic                      reg_rd_in,
  input wire logic [7:0]                reg_rdata_out,
  input wire logic                      reset_out,
  input wire logic                      main_supply_fail_out,
  input wire logic                      early_low_supply_n_out,
  input wire logic                      second_supply_fail_n_out,
  input wire logic                      battery_active_out,
  input wire logic                      watchdog_out_n,
  input wire logic                      watchdog_oe_out,
  input wire logic                      bus_enable_out
);
  // Shortest settings, with slack for tick phase
  localparam int unsigned HOLD_MIN = 50 * TICKS_PER_MS * TICK_CYCLES * 9 / 10;
  localparam int unsigned WD_MIN   = 25 * TICKS_PER_MS * TICK_CYCLES * 9 / 10;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  logic        rst_act;
  logic [31:0] good_q;
  logic [31:0] quiet_q;
  assign rst_act = (reset_out == RESET_ACTIVE_HIGH);
  always_ff @(posedge clk_in) begin
    if (rst_in || !sense_in.main_above_trip) begin
      good_q <= 32'h0;
    end else if (good_q != 32'hffffffff) begin
      good_q <= good_q + 32'h1;
    end
  end
  // A restart follows the last bus edge, so quiet time is never shorter
  always_ff @(posedge clk_in) begin
    if (rst_in || rst_act || $changed(scl_in) || $changed(sda_in)) begin
      quiet_q <= 32'h0;
    end else if (quiet_q != 32'hffffffff) begin
      quiet_q <= quiet_q + 32'h1;
    end
  end
  sequence main_low_s;
    !sense_in.main_above_trip [*5];
  endsequence
  sequence main_good_s;
    sense_in.main_above_trip [*5];
  endsequence
  a_low_main_reset: assert property (main_low_s |-> rst_act)
    else $error("reset not active while main low");
  a_low_main_fail: assert property (main_low_s |-> main_supply_fail_out && !early_low_supply_n_out)
    else $error("main fail flags wrong while main low");
  a_fail_clears_late: assert property ($fell(main_supply_fail_out) |-> good_q >= HOLD_MIN)
    else $error("main fail cleared before hold time");
  a_release_after_hold: assert property ($changed(reset_out) && !rst_act |-> good_q >= HOLD_MIN)
    else $error("reset released before hold time");
  a_second_tracks: assert property ((sense_in.main_above_trip && $stable(sense_in.second_above_trip)) [*5]
    |-> second_supply_fail_n_out == sense_in.second_above_trip)
    else $error("second fail does not follow comparator");
  a_main_no_batt: assert property (main_good_s |-> !battery_active_out)
    else $error("backup selected while main good");
  a_batt_no_bus: assert property (battery_active_out |-> !bus_enable_out)
    else $error("bus enabled on backup");
  a_wd_pin_low: assert property (watchdog_oe_out |-> !watchdog_out_n)
    else $error("watchdog pin not low when active");
  a_wd_after_period: assert property ($rose(watchdog_oe_out) |-> quiet_q >= WD_MIN)
    else $error("watchdog fired early");
  a_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
    else $error("read data outside read slot");
endmodule
bind supervisor_reset_watchdog supervisor_props #(.RESET_ACTIVE_HIGH(RESET_ACTIVE_HIGH),
  .TICK_CYCLES(TICK_CYCLES), .TICKS_PER_MS(TICKS_PER_MS)) i_props (
  .clk_in(clk_in), .rst_in(rst_in), .sense_in(sense_in), .scl_in(scl_in), .sda_in(sda_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .reset_out(reset_out),
  .main_supply_fail_out(main_supply_fail_out), .early_low_supply_n_out(early_low_supply_n_out),
  .second_supply_fail_n_out(second_supply_fail_n_out), .battery_active_out(battery_active_out),
  .watchdog_out_n(watchdog_out_n), .watchdog_oe_out(watchdog_oe_out),
  .bus_enable_out(bus_enable_out));

//--- host_bus_model.sv
`timescale 1ns/1ps
module host_bus_model (
  input  wire logic clk_in,
  output logic      scl_out,
  output logic      sda_out
);
  // Released lines read high through the pull-ups; clock idles high
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  task automatic drive(input logic c, input logic d, input int step);
    @(posedge clk_in);
    scl_out <= c;
    sda_out <= d;
    repeat (step - 1) @(posedge clk_in);
  endtask
  task automatic restart_min(input int step);
    drive(1'b1, 1'b0, step);
    drive(1'b0, 1'b0, step);
    drive(1'b1, 1'b0, step);
    drive(1'b1, 1'b1, step);
  endtask
  // Ninth bit released: nobody acknowledges, still a complete frame
  task automatic send_byte(input logic [7:0] b, input int step);
    logic [8:0] bits;
    bits = {b, 1'b1};
    drive(1'b1, 1'b0, step);
    for (int i = 8; i >= 0; i--) begin
      drive(1'b0, bits[i], step);
      drive(1'b1, bits[i], step);
    end
    drive(1'b0, 1'b0, step);
    drive(1'b1, 1'b0, step);
    drive(1'b1, 1'b1, step);
  endtask
endmodule

//--- testbench.sv
`timescale 1ns/1ps
module testbench;
  localparam int TC   = 2;
  localparam int HOLD = 50 * TC;
  localparam int WD0  = 25 * TC;
  localparam int WD1  = 200 * TC;
  localparam int DEB  = 1000 * TC;
  logic                      clk_in;
  logic                      rst_in;
  supervisor_pkg::sense_type sense_in;
  logic                      manual_reset_in_n;
  logic                      write_protect_in;
  logic                      scl;
  logic                      sda;
  logic [3:0]                reg_addr_in;
  logic [7:0]                reg_wdata_in;
  logic                      reg_wr_in;
  logic                      reg_rd_in;
  logic                      store_stop_in;
  logic [7:0]                reg_rdata_out;
  logic                      reset_out;
  logic                      main_supply_fail_out;
  logic                      early_low_supply_n_out;
  logic                      second_supply_fail_n_out;
  logic                      battery_active_out;
  logic                      watchdog_out_n;
  logic                      watchdog_oe_out;
  logic                      bus_enable_out;
  int                        failures;
  int                        checked;
  int                        seed;
  int                        n;
  int                        batt_m;
  logic [7:0]                ctrl_m;
  logic [7:0]                d;
  logic [7:0]                exp_q[$];
  supervisor_reset_watchdog #(.TICK_CYCLES(TC), .TICKS_PER_MS(1)) i_dut (
    .clk_in(clk_in), .rst_in(rst_in), .sense_in(sense_in), .manual_reset_in_n(manual_reset_in_n),
    .write_protect_in(write_protect_in), .scl_in(scl), .sda_in(sda), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .store_stop_in(store_stop_in), .reg_rdata_out(reg_rdata_out), .reset_out(reset_out),
    .main_supply_fail_out(main_supply_fail_out), .early_low_supply_n_out(early_low_supply_n_out),
    .second_supply_fail_n_out(second_supply_fail_n_out), .battery_active_out(battery_active_out),
    .watchdog_out_n(watchdog_out_n), .watchdog_oe_out(watchdog_oe_out),
    .bus_enable_out(bus_enable_out));
  host_bus_model i_host (.clk_in(clk_in), .scl_out(scl), .sda_out(sda));
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  task automatic bump(input logic bad, input string what);
    checked++;
    if (bad) begin
      failures++;
      $display("Error at %0t: %s", $time, what);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    bump(got !== exp, "pin level mismatch");
  endtask
  task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
    bump(got !== exp, "register data mismatch");
  endtask
  task automatic cmp_count(input int cnt, input int lo, input int hi);
    bump(cnt < lo || cnt > hi, "cycle count out of range");
  endtask
  task automatic wait_sig(input bit wd, input logic lvl, input int bound);
    n = 0;
    while ((wd ? watchdog_oe_out : reset_out) !== lvl && n < bound) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    if ((wd ? watchdog_oe_out : reset_out) !== lvl) begin
      bump(1'b1, "wait timed out");
      summarize();
    end
  endtask
  task automatic reg_write(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= v;
    reg_wr_in <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic reg_read(input logic [3:0] a, input logic [7:0] v);
    exp_q.push_back(v);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    @(negedge clk_in);
    cmp_reg(reg_rdata_out, exp_q.pop_front());
  endtask
  task automatic store();
    @(posedge clk_in);
    store_stop_in <= 1'b1;
    @(posedge clk_in);
    store_stop_in <= 1'b0;
  endtask
  // Source choice with hysteresis: inside the band the last source stays
  task automatic supply(input logic m, input logic hi, input logic lo, input logic s2);
    @(posedge clk_in);
    sense_in <= {m, hi, lo, s2, 1'b1};
    if (m || hi) batt_m = 0;
    else if (lo) batt_m = 1;
    repeat (6) @(posedge clk_in);
    #1;
    cmp_bit(battery_active_out, 1'(batt_m));
  endtask
  task automatic summarize();
    $display("Checks: %0d, mismatches: %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    seed = 32'h4d9d8720;
    failures = 0;
    checked = 0;
    batt_m = 0;
    ctrl_m = 8'h00;
    rst_in <= 1'b1;
    sense_in <= 5'b11011;
    manual_reset_in_n <= 1'b1;
    write_protect_in <= 1'b0;
    reg_addr_in <= 4'h0;
    reg_wdata_in <= 8'h00;
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b0;
    store_stop_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    #1;
    cmp_bit(reset_out, 1'b0);
    wait_sig(1'b0, 1'b1, HOLD + 40);
    cmp_count(n, HOLD, HOLD + 12);
    @(posedge clk_in);
    #1;
    cmp_bit(main_supply_fail_out, 1'b0);
    reg_read(4'h1, 8'h00);
    wait_sig(1'b1, 1'b1, WD0 + 40);
    cmp_count(n, WD0 - 8, WD0 + 12);
    cmp_bit(watchdog_out_n, 1'b0);
    i_host.restart_min(4);
    wait_sig(1'b1, 1'b0, 20);
    wait_sig(1'b1, 1'b1, WD0 + 40);
    i_host.send_byte(8'($random(seed)), 2);
    wait_sig(1'b1, 1'b0, 20);
    reg_read(4'h0, ctrl_m);
    for (int i = 0; i < 6; i++) begin
      d = 8'($random(seed));
      @(posedge clk_in);
      write_protect_in <= i[0];
      repeat (2) @(posedge clk_in);
      reg_write(4'h0, d);
      reg_read(4'h0, ctrl_m);
      store();
      if (!i[0]) ctrl_m = d & 8'he1;
      reg_read(4'h0, ctrl_m);
    end
    @(posedge clk_in);
    write_protect_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    reg_write(4'h0, 8'h20);
    store();
    reg_read(4'h0, 8'h20);
    reg_read(4'h7, 8'h00);
    i_host.restart_min(2);
    wait_sig(1'b1, 1'b0, 20);
    wait_sig(1'b1, 1'b1, WD1 + 40);
    cmp_count(n, WD1 - 8, WD1 + 12);
    @(posedge clk_in);
    manual_reset_in_n <= 1'b0;
    wait_sig(1'b0, 1'b0, DEB + 40);
    repeat (50) @(posedge clk_in);
    manual_reset_in_n <= 1'b1;
    wait_sig(1'b0, 1'b1, DEB + HOLD + 40);
    cmp_count(n, HOLD, DEB + HOLD + 20);
    supply(1'b0, 1'b1, 1'b0, 1'b1);
    cmp_bit(reset_out, 1'b0);
    cmp_bit(early_low_supply_n_out, 1'b0);
    cmp_bit(main_supply_fail_out, 1'b1);
    supply(1'b0, 1'b0, 1'b1, 1'b1);
    cmp_bit(bus_enable_out, 1'b0);
    reg_read(4'h1, 8'h00);
    supply(1'b0, 1'b0, 1'b0, 1'b1);
    supply(1'b0, 1'b1, 1'b0, 1'b0);
    cmp_bit(second_supply_fail_n_out, 1'b0);
    supply(1'b1, 1'b1, 1'b0, 1'b1);
    cmp_bit(second_supply_fail_n_out, 1'b1);
    cmp_bit(main_supply_fail_out, 1'b1);
    wait_sig(1'b0, 1'b1, HOLD + 40);
    cmp_count(n, HOLD - 12, HOLD + 12);
    repeat (2) @(posedge clk_in);
    #1;
    cmp_bit(main_supply_fail_out, 1'b0);
    summarize();
  end
endmodule
